// File: lbb_consts.svh
`ifndef LBB_CONSTS_SVH
`define LBB_CONSTS_SVH

// Register byte addresses on the serial control interface
`define LBB_ADDR_PHASE2   8'h51
`define LBB_ADDR_PHASE3   8'h52
`define LBB_ADDR_PHASE4   8'h53
`define LBB_ADDR_PAUSE    8'h54
`define LBB_ADDR_DUTY     8'h55
`define LBB_ADDR_ON_DUR   8'h56

// Field layout
`define LBB_LEN_W         7
`define LBB_DUR_W         5
`define LBB_RST_VAL       8'h00

// Oscillator and timing
`define LBB_OSC_HZ        32000
`define LBB_STEP_MS       64
`define LBB_PERIOD_MS     8
`define LBB_STEP_TICKS    (`LBB_OSC_HZ * `LBB_STEP_MS / 1000)
`define LBB_PERIOD_TICKS  (`LBB_OSC_HZ * `LBB_PERIOD_MS / 1000)
`define LBB_SLOTS         32
`define LBB_SLOT_TICKS    (`LBB_PERIOD_TICKS / `LBB_SLOTS)
`define LBB_TB_W          11

`endif

// File: lbb_pkg.sv
`default_nettype none

package lbb_pkg;

    typedef struct packed {
        logic [6:0] phase2_len;
        logic [6:0] phase3_len;
        logic [6:0] phase4_len;
        logic [6:0] pause_len;
        logic [4:0] duty_code;
        logic [4:0] on_duration;
    } lbb_cfg_t;

    // Phase states first; their codes index the length table
    typedef enum logic [2:0] {
        LBB_PH1,
        LBB_PH2,
        LBB_PH3,
        LBB_PH4,
        LBB_PAUSE,
        LBB_IDLE
    } lbb_state_t;

endpackage : lbb_pkg

`default_nettype wire

// File: lbb_timebase.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbb_consts.svh"

module lbb_timebase (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       osc_32k,
    output var  logic       step_pulse,
    output wire logic [4:0] duty_slot
);

    logic                 sync1_reg;
    logic                 sync2_reg;
    logic                 sync3_reg;
    logic [`LBB_TB_W-1:0] cnt_reg;
    logic                 osc_rise;

    localparam logic [`LBB_TB_W-1:0] CNT_MAX =
        `LBB_TB_W'(`LBB_STEP_TICKS - 1);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= osc_32k;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign osc_rise = sync2_reg & ~sync3_reg;

    // Oscillator edge counter, 64 ms per wrap
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_reg <= '0;
        else if (osc_rise)
            cnt_reg <= (cnt_reg == CNT_MAX) ? '0 : cnt_reg + 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            step_pulse <= 1'b0;
        else
            step_pulse <= osc_rise && (cnt_reg == CNT_MAX);
    end

    // 8 ms period is the low 8 bits; slot is 8 ticks (250 us)
    assign duty_slot = cnt_reg[7:3];

endmodule : lbb_timebase

`default_nettype wire

// File: lbb_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbb_consts.svh"

// Overview of operation
// - Second phase lasts its 7-bit length times 64 ms.
// - Third phase lasts its 7-bit length times 64 ms.
// - Fourth phase lasts its 7-bit length times 64 ms.
// - Pause lasts its 7-bit length times 64 ms; zero means no pause.
// - On-signal has 8 ms period, high (duty+1)/32 of it.
// - Duty zero gives 250 us high, 7.75 ms low.
// - Duty all-ones keeps the on-signal always high.
// - On-time equals its 5-bit value times 64 ms.
// - Unused register bits read zero and ignore writes.
// - All these registers clear on power-on reset.
// - Timing and duty fields read/write; unused bits read-only.
// - First phase lasts its externally held length times 64 ms.
module lbb_channel (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              osc_32k,
    input  wire logic              chan_enable,
    input  wire logic [6:0]        phase1_len,
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output var  logic [7:0]        reg_rdata,
    output var  logic              chan_on_signal,
    output var  lbb_pkg::lbb_state_t phase_state
);

    lbb_pkg::lbb_cfg_t cfg_reg;
    logic [6:0]        step_cnt_reg;
    logic              step_pulse;
    logic [4:0]        duty_slot;
    logic              pwm_raw;
    logic              on_next;
    logic              active_phase;
    logic [4:0][6:0]   lens;
    logic [6:0]        cur_len;
    logic              first_reg;

    lbb_timebase u_timebase (
        .clk        (clk),
        .nrst       (nrst),
        .osc_32k    (osc_32k),
        .step_pulse (step_pulse),
        .duty_slot  (duty_slot)
    );

    function automatic lbb_pkg::lbb_state_t seek_next(
        input lbb_pkg::lbb_state_t cur,
        input logic [4:0][6:0]     tbl
    );
        int unsigned         base;
        int unsigned         idx;
        lbb_pkg::lbb_state_t res;
        res  = lbb_pkg::LBB_IDLE;
        base = (cur == lbb_pkg::LBB_IDLE) ? 4 : int'(cur);
        for (int unsigned k = 1; k <= 5; k++)
        begin
            idx = (base + k) % 5;
            if (res == lbb_pkg::LBB_IDLE && tbl[idx] != 7'h00)
                res = lbb_pkg::lbb_state_t'(idx[2:0]);
        end
        return res;
    endfunction : seek_next

    function automatic logic [7:0] read_mux(
        input logic [7:0]        addr,
        input lbb_pkg::lbb_cfg_t c
    );
        logic [7:0] d;
        d = `LBB_RST_VAL;
        case (addr)
            `LBB_ADDR_PHASE2: d = {1'b0, c.phase2_len};
            `LBB_ADDR_PHASE3: d = {1'b0, c.phase3_len};
            `LBB_ADDR_PHASE4: d = {1'b0, c.phase4_len};
            `LBB_ADDR_PAUSE:  d = {1'b0, c.pause_len};
            `LBB_ADDR_DUTY:   d = {3'h0, c.duty_code};
            `LBB_ADDR_ON_DUR: d = {3'h0, c.on_duration};
            default:          d = `LBB_RST_VAL;
        endcase
        return d;
    endfunction : read_mux

    // Register writes; upper unused bits are dropped
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cfg_reg <= '0;
        else if (reg_wr_en)
        begin
            case (reg_addr)
                `LBB_ADDR_PHASE2: cfg_reg.phase2_len  <= reg_wdata[6:0];
                `LBB_ADDR_PHASE3: cfg_reg.phase3_len  <= reg_wdata[6:0];
                `LBB_ADDR_PHASE4: cfg_reg.phase4_len  <= reg_wdata[6:0];
                `LBB_ADDR_PAUSE:  cfg_reg.pause_len   <= reg_wdata[6:0];
                `LBB_ADDR_DUTY:   cfg_reg.duty_code   <= reg_wdata[4:0];
                `LBB_ADDR_ON_DUR: cfg_reg.on_duration <= reg_wdata[4:0];
                default:          ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= `LBB_RST_VAL;
        else if (reg_rd_en)
            reg_rdata <= read_mux(reg_addr, cfg_reg);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            first_reg <= 1'b1;
        else
            first_reg <= 1'b0;
    end

    assign lens = {cfg_reg.pause_len, cfg_reg.phase4_len,
                   cfg_reg.phase3_len, cfg_reg.phase2_len, phase1_len};

    always_comb
    begin
        cur_len = 7'h00;
        if (phase_state != lbb_pkg::LBB_IDLE)
            cur_len = lens[phase_state];
    end

    // Phase sequencer, advanced on 64 ms steps
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_state  <= lbb_pkg::LBB_IDLE;
            step_cnt_reg <= 7'h00;
        end
        else if (!chan_enable)
        begin
            phase_state  <= lbb_pkg::LBB_IDLE;
            step_cnt_reg <= 7'h00;
        end
        else if (phase_state == lbb_pkg::LBB_IDLE)
        begin
            phase_state  <= seek_next(phase_state, lens);
            step_cnt_reg <= 7'h00;
        end
        else if (step_pulse)
        begin
            if (step_cnt_reg + 7'h01 >= cur_len)
            begin
                phase_state  <= seek_next(phase_state, lens);
                step_cnt_reg <= 7'h00;
            end
            else
                step_cnt_reg <= step_cnt_reg + 7'h01;
        end
    end

    // Slot index within the 8 ms period versus duty code
    assign pwm_raw = (duty_slot <= cfg_reg.duty_code);

    assign active_phase = (phase_state != lbb_pkg::LBB_IDLE) &&
                          (phase_state != lbb_pkg::LBB_PAUSE);

    assign on_next = chan_enable && active_phase && pwm_raw &&
                     (step_cnt_reg < {2'b00, cfg_reg.on_duration});

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            chan_on_signal <= 1'b0;
        else
            chan_on_signal <= on_next;
    end

    sequence s_wr_phase2;
        reg_wr_en && reg_addr == `LBB_ADDR_PHASE2;
    endsequence

    sequence s_enter_ph3;
        $changed(phase_state) && phase_state == lbb_pkg::LBB_PH3;
    endsequence

    a_phase2_length: assert property (@(posedge clk) disable iff (!nrst)
        phase_state == lbb_pkg::LBB_PH2 |-> step_cnt_reg < cfg_reg.phase2_len)
        else $error("phase two overran its length");
    a_phase3_length: assert property (@(posedge clk) disable iff (!nrst)
        phase_state == lbb_pkg::LBB_PH3 |-> step_cnt_reg < cfg_reg.phase3_len)
        else $error("phase three overran its length");
    a_phase4_length: assert property (@(posedge clk) disable iff (!nrst)
        phase_state == lbb_pkg::LBB_PH4 |-> step_cnt_reg < cfg_reg.phase4_len)
        else $error("phase four overran its length");
    a_pause_skip: assert property (@(posedge clk) disable iff (!nrst)
        cfg_reg.pause_len == 7'h00 && $stable(cfg_reg.pause_len)
        |-> phase_state != lbb_pkg::LBB_PAUSE)
        else $error("zero pause was entered");
    a_duty_window: assert property (@(posedge clk) disable iff (!nrst)
        duty_slot > cfg_reg.duty_code |=> !chan_on_signal)
        else $error("on-signal high outside duty window");
    a_duty_zero_low: assert property (@(posedge clk) disable iff (!nrst)
        cfg_reg.duty_code == 5'h00 |-> pwm_raw == (duty_slot == 5'h00))
        else $error("duty zero high time wrong");
    a_duty_full_on: assert property (@(posedge clk) disable iff (!nrst)
        cfg_reg.duty_code == 5'h1F && chan_enable && active_phase &&
        step_cnt_reg < {2'b00, cfg_reg.on_duration} |=> chan_on_signal)
        else $error("full duty not continuously high");
    a_on_time_end: assert property (@(posedge clk) disable iff (!nrst)
        step_cnt_reg >= {2'b00, cfg_reg.on_duration} |=> !chan_on_signal)
        else $error("on-signal beyond on-time");
    a_unused_zero: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd_en && reg_addr == `LBB_ADDR_DUTY |=> reg_rdata[7:5] == 3'h0)
        else $error("unused bits read nonzero");
    a_reset_clear: assert property (@(posedge clk) disable iff (!nrst)
        first_reg |-> cfg_reg == '0)
        else $error("registers not clear after reset");
    a_write_store: assert property (@(posedge clk) disable iff (!nrst)
        s_wr_phase2 |=> cfg_reg.phase2_len == $past(reg_wdata[6:0]))
        else $error("phase two write not stored");
    a_phase1_length: assert property (@(posedge clk) disable iff (!nrst)
        phase_state == lbb_pkg::LBB_PH1 && $stable(phase1_len)
        |-> step_cnt_reg < phase1_len)
        else $error("phase one overran its length");
    a_phase_order: assert property (@(posedge clk) disable iff (!nrst)
        s_enter_ph3 |-> $past(phase_state) == lbb_pkg::LBB_PH2 ||
            $past(cfg_reg.phase2_len) == 7'h00)
        else $error("phase three entered out of order");
    a_step_advance: assert property (@(posedge clk) disable iff (!nrst)
        chan_enable && $past(chan_enable) && !step_pulse &&
        phase_state != lbb_pkg::LBB_IDLE &&
        $past(phase_state) != lbb_pkg::LBB_IDLE
        |=> $stable(step_cnt_reg) || !chan_enable)
        else $error("step count moved without a 64 ms step");

endmodule : lbb_channel

`default_nettype wire

// File: tb_led_channel_b_blink_pattern.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbb_consts.svh"

module tb_led_channel_b_blink_pattern;
    localparam int OSC_CLKS = 4;
    localparam int STEP     = `LBB_STEP_TICKS * OSC_CLKS;
    localparam int PERIOD   = `LBB_PERIOD_TICKS * OSC_CLKS;
    localparam int SLOT     = `LBB_SLOT_TICKS * OSC_CLKS;

    logic                clk         = 1'b0;
    logic                nrst        = 1'b0;
    logic                osc_32k     = 1'b0;
    logic                chan_enable = 1'b0;
    logic [6:0]          phase1_len  = 7'h00;
    logic                reg_wr_en   = 1'b0;
    logic                reg_rd_en   = 1'b0;
    logic [7:0]          reg_addr    = 8'h00;
    logic [7:0]          reg_wdata   = 8'h00;
    logic [7:0]          reg_rdata;
    logic                chan_on_signal;
    lbb_pkg::lbb_state_t phase_state;
    int                  mismatches  = 0;
    int                  num_checks  = 0;

    lbb_channel uut (
        .clk            (clk),
        .nrst           (nrst),
        .osc_32k        (osc_32k),
        .chan_enable    (chan_enable),
        .phase1_len     (phase1_len),
        .reg_wr_en      (reg_wr_en),
        .reg_rd_en      (reg_rd_en),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_rdata      (reg_rdata),
        .chan_on_signal (chan_on_signal),
        .phase_state    (phase_state)
    );

    always #2 clk = ~clk;
    // Oscillator sped up to one tick per 4 clocks to keep the run short
    always #8 osc_32k = ~osc_32k;

    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask : rd

    task automatic wait_state(input lbb_pkg::lbb_state_t st,
                              input int bound, output int n);
        n = 0;
        while (phase_state !== st && n < bound)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= bound)
        begin
            mismatches++;
            $display("[ERR] %0t phase wait timed out", $time);
            complete_run();
        end
    endtask : wait_state

    task automatic t_reset_values;
        logic [7:0] d;
        for (int i = 0; i < 6; i++)
        begin
            rd(8'h51 + i[7:0], d);
            check(d, 8'h00);
        end
    endtask : t_reset_values

    task automatic t_access;
        logic [7:0] d;
        logic [7:0] pat [2] = '{8'hFF, 8'hAA};
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 6; i++)
            begin
                wr(8'h51 + i[7:0], pat[p]);
                rd(8'h51 + i[7:0], d);
                check(d, pat[p] & ((i < 4) ? 8'h7F : 8'h1F));
            end
        wr(8'h57, 8'hFF);
        rd(8'h57, d);
        check(d, 8'h00);
    endtask : t_access

    // Registers hold nonzero values here, so a missed clear shows
    task automatic t_reset_mid;
        logic [7:0] d;
        @(negedge clk);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            rd(8'h51 + i[7:0], d);
            check(d, 8'h00);
        end
    endtask : t_reset_mid

    task automatic t_duty;
        int n;
        int hi;
        logic [4:0] codes [3] = '{5'h00, 5'h0F, 5'h1F};
        phase1_len = 7'h7F;
        wr(`LBB_ADDR_ON_DUR, 8'h1F);
        for (int k = 0; k < 3; k++)
        begin
            wr(`LBB_ADDR_DUTY, {3'h0, codes[k]});
            chan_enable = 1'b1;
            wait_state(lbb_pkg::LBB_PH1, 20, n);
            repeat (10) @(negedge clk);
            hi = 0;
            repeat (PERIOD)
            begin
                @(negedge clk);
                hi += int'(chan_on_signal === 1'b1);
            end
            check(hi, (codes[k] + 1) * SLOT);
            chan_enable = 1'b0;
            wait_state(lbb_pkg::LBB_IDLE, 4, n);
        end
    endtask : t_duty

    task automatic t_sequence;
        int n;
        wr(`LBB_ADDR_PHASE2, 8'h02);
        wr(`LBB_ADDR_PHASE3, 8'h01);
        wr(`LBB_ADDR_PHASE4, 8'h00);
        wr(`LBB_ADDR_PAUSE, 8'h01);
        wr(`LBB_ADDR_DUTY, 8'h1F);
        wr(`LBB_ADDR_ON_DUR, 8'h01);
        phase1_len = 7'h01;
        chan_enable = 1'b1;
        wait_state(lbb_pkg::LBB_PH1, 20, n);
        wait_state(lbb_pkg::LBB_PH2, STEP + 20, n);
        repeat (100) @(negedge clk);
        check(chan_on_signal, 1'b1);
        repeat (STEP) @(negedge clk);
        check(chan_on_signal, 1'b0);
        wait_state(lbb_pkg::LBB_PH3, STEP, n);
        check(n + STEP + 100, 2 * STEP);
        repeat (100) @(negedge clk);
        check(chan_on_signal, 1'b1);
        wait_state(lbb_pkg::LBB_PAUSE, 2 * STEP, n);
        check(n + 100, STEP);
        repeat (100) @(negedge clk);
        check(chan_on_signal, 1'b0);
        wait_state(lbb_pkg::LBB_PH1, 2 * STEP, n);
        check(n + 100, STEP);
        wait_state(lbb_pkg::LBB_PH2, 2 * STEP, n);
        check(n, STEP);
        chan_enable = 1'b0;
    endtask : t_sequence

    initial
    begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        t_reset_values();
        t_access();
        t_reset_mid();
        t_duty();
        t_sequence();
        complete_run();
    end
endmodule : tb_led_channel_b_blink_pattern

`default_nettype wire
